// ===== hdl/trend_transfer_handshake.sv
// Panel-side trend request and transfer handshake engine.
// Assumes an Avalon-MM master for registers and a controller-side
// agent that serves fetch and clear requests on the shared areas.
`timescale 1ns/100ps
`include "trend_xfer_params.svh"

module trend_transfer_handshake #(
  parameter int ACQ_CYCLES = `TRD_ACQ_MS * `TRD_CLK_KHZ,
  parameter int TIM_CYCLES = `TRD_TIMED_MS * `TRD_CLK_KHZ
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // Avalon-MM slave
  input  wire logic [5:0]              avsAddress,
  input  wire logic                    avsRead,
  input  wire logic                    avsWrite,
  input  wire logic [31:0]             avsWritedata,
  output logic [31:0]                  avsReaddata,
  output logic                         avsWaitrequest,
  // Shared areas as seen from the controller
  output logic [`TRD_AREA_W-1:0]       reqAreaOut,
  input  wire logic [`TRD_AREA_W-1:0]  xfer1In,
  input  wire logic [`TRD_AREA_W-1:0]  xfer2In,
  // Trend fetch request
  output logic                         fetchValid,
  input  wire logic                    fetchReady,
  output logic [`TRD_IDX_W-1:0]        fetchTrend,
  output logic                         fetchWhole,
  output logic                         fetchBuffer2,
  output logic                         fetchTimed,
  // Transfer area clear request
  output logic                         clrValid,
  input  wire logic                    clrReady,
  output logic                         clrArea2,
  output logic [`TRD_AREA_W-1:0]       clrMask
);

  trend_xfer_pkg::trd_state_t q;
  trend_xfer_pkg::trd_state_t d;

  logic [`TRD_AREA_W-1:0] scanVec;
  logic                   scanAny;
  logic [`TRD_IDX_W-1:0]  scanIdx;
  logic                   acqTick;
  logic                   timTick;
  logic                   busReq;

  // ==========================================================
  // Register read decode
  function automatic logic [31:0] readMux(
    input trend_xfer_pkg::trd_state_t s,
    input logic [5:0]                 a
  );
    case (a)
      `TRD_OFF_CTRL:    readMux = {30'h0000_0000, s.page, s.enable};
      `TRD_OFF_SHOW:    readMux = {16'h0000, s.showMask};
      `TRD_OFF_TIMED:   readMux = {16'h0000, s.timedMask};
      `TRD_OFF_WHOLE:   readMux = {16'h0000, s.wholeMask};
      `TRD_OFF_DOUBLE:  readMux = {16'h0000, s.doubleMask};
      `TRD_OFF_ACQPER:  readMux = s.acqPer;
      `TRD_OFF_TIMPER:  readMux = s.timPer;
      `TRD_OFF_STATUS:  readMux = {22'h00_0000, s.area, s.trend, s.st};
      `TRD_OFF_PEND:    readMux = {s.pend2, s.pend1};
      `TRD_OFF_COUNT:   readMux = s.fetchCount;
      `TRD_OFF_REQAREA: readMux = {16'h0000, s.reqArea};
      default:          readMux = `TRD_ZERO32;
    endcase
  endfunction

  // ==========================================================
  // Trend picker over the area being served
  always_comb
  begin
    case (q.area)
      2'd0:    scanVec = q.pendT & `TRD_TREND_MASK;
      2'd1:    scanVec = q.pend1 & `TRD_TREND_MASK;
      default: scanVec = q.pend2 & `TRD_TREND_MASK;
    endcase
  end

  lowest_bit_pick #(
    .W  (`TRD_AREA_W),
    .IW (`TRD_IDX_W)
  ) picker (
    .vec (scanVec),
    .any (scanAny),
    .idx (scanIdx)
  );

  assign busReq  = avsRead | avsWrite;
  assign acqTick = q.enable && (q.acqCnt + `TRD_ONE32 >= q.acqPer);
  assign timTick = q.enable && (q.timCnt + `TRD_ONE32 >= q.timPer);

  // ==========================================================
  // Next state
  always_comb
  begin
    d = q;
    d.ack = busReq & ~q.ack;
    if (busReq && !q.ack)
      d.rdata = readMux(q, avsAddress);
    if (avsWrite && q.ack)
    begin
      case (avsAddress)
        `TRD_OFF_CTRL:
        begin
          d.enable = avsWritedata[`TRD_CTRL_EN];
          d.page   = avsWritedata[`TRD_CTRL_PAGE];
        end
        `TRD_OFF_SHOW:   d.showMask   = avsWritedata[15:0];
        `TRD_OFF_TIMED:  d.timedMask  = avsWritedata[15:0];
        `TRD_OFF_WHOLE:  d.wholeMask  = avsWritedata[15:0];
        `TRD_OFF_DOUBLE: d.doubleMask = avsWritedata[15:0];
        `TRD_OFF_ACQPER: d.acqPer     = avsWritedata;
        `TRD_OFF_TIMPER: d.timPer     = avsWritedata;
        default:         d.enable     = q.enable;
      endcase
    end

    // Request area follows the page shown
    d.reqArea = q.page ? (q.showMask & `TRD_TREND_MASK)
                       : `TRD_RST_MASK;

    // Timers
    d.acqCnt = acqTick || !q.enable ? `TRD_ZERO32 : q.acqCnt + `TRD_ONE32;
    d.timCnt = timTick || !q.enable ? `TRD_ZERO32 : q.timCnt + `TRD_ONE32;

    // Sequencer
    case (q.st)
      trend_xfer_pkg::ST_IDLE:
      begin
        if (q.pendT != `TRD_RST_MASK)
        begin
          d.area = 2'd0;
          d.st   = trend_xfer_pkg::ST_SCAN;
        end
        else if (q.pend1 != `TRD_RST_MASK)
        begin
          d.area = 2'd1;
          d.st   = trend_xfer_pkg::ST_SCAN;
        end
        else if (q.pend2 != `TRD_RST_MASK)
        begin
          d.area = 2'd2;
          d.st   = trend_xfer_pkg::ST_SCAN;
        end
        else if (q.acqDue)
        begin
          d.acqDue = 1'b0;
          // Only a set group bit counts as a trigger
          if (xfer1In[`TRD_GROUP_BIT])
            d.pend1 = xfer1In;
          if (xfer2In[`TRD_GROUP_BIT])
            d.pend2 = xfer2In & (q.doubleMask | `TRD_GROUP_MASK);
        end
      end
      trend_xfer_pkg::ST_SCAN:
      begin
        if (scanAny)
        begin
          d.trend  = scanIdx;
          d.whole  = (q.area != 2'd0) && q.wholeMask[scanIdx];
          d.fetchV = 1'b1;
          d.st     = trend_xfer_pkg::ST_FETCH;
        end
        else if (q.area == 2'd0)
        begin
          d.pendT = `TRD_RST_MASK;
          d.st    = trend_xfer_pkg::ST_IDLE;
        end
        else
        begin
          d.clrMask = q.clrMask | `TRD_GROUP_MASK;
          d.clrV    = 1'b1;
          d.st      = trend_xfer_pkg::ST_CLEAR;
        end
      end
      trend_xfer_pkg::ST_FETCH:
      begin
        if (fetchReady)
        begin
          d.fetchV     = 1'b0;
          d.fetchCount = q.fetchCount + `TRD_ONE32;
          d.st         = trend_xfer_pkg::ST_SCAN;
          case (q.area)
            2'd0: d.pendT[q.trend] = 1'b0;
            2'd1:
            begin
              d.pend1[q.trend]   = 1'b0;
              d.clrMask[q.trend] = 1'b1;
            end
            default:
            begin
              d.pend2[q.trend]   = 1'b0;
              d.clrMask[q.trend] = 1'b1;
            end
          endcase
        end
      end
      trend_xfer_pkg::ST_CLEAR:
      begin
        if (clrReady)
        begin
          d.clrV    = 1'b0;
          d.clrMask = `TRD_RST_MASK;
          if (q.area == 2'd1)
            d.pend1 = `TRD_RST_MASK;
          else
            d.pend2 = `TRD_RST_MASK;
          d.st = trend_xfer_pkg::ST_IDLE;
        end
      end
      default:
      begin
        d.st     = trend_xfer_pkg::ST_IDLE;
        d.fetchV = 1'b0;
        d.clrV   = 1'b0;
      end
    endcase

    // Ticks set after the sequencer so a tick is never lost
    if (acqTick)
      d.acqDue = 1'b1;
    if (timTick)
      d.pendT = d.pendT | (q.timedMask & `TRD_TREND_MASK);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q            <= '0;
      q.st         <= trend_xfer_pkg::ST_IDLE;
      q.acqPer     <= 32'(ACQ_CYCLES);
      q.timPer     <= 32'(TIM_CYCLES);
    end
    else
      q <= d;
  end

  // ==========================================================
  // Outputs
  assign avsWaitrequest = busReq & ~q.ack;
  assign avsReaddata    = q.rdata;
  assign reqAreaOut     = q.reqArea;
  assign fetchValid     = q.fetchV;
  assign fetchTrend     = q.trend;
  assign fetchWhole     = q.whole;
  assign fetchBuffer2   = (q.area == 2'd2);
  assign fetchTimed     = (q.area == 2'd0);
  assign clrValid       = q.clrV;
  assign clrArea2       = (q.area == 2'd2);
  assign clrMask        = q.clrMask;

endmodule // trend_transfer_handshake

// ===== hdl/trend_xfer_params.svh
// Constants for the trend request and transfer handshake block.
// Assumes a 20 MHz clock and 16-bit shared handshake words.
`ifndef TREND_XFER_PARAMS_SVH
`define TREND_XFER_PARAMS_SVH

// ==========================================================
// Area layout
`define TRD_AREA_W      16
`define TRD_GROUP_BIT   15
`define TRD_TREND_MASK  16'h7FFF
`define TRD_GROUP_MASK  16'h8000
`define TRD_IDX_W       4

// ==========================================================
// Timing
`define TRD_CLK_KHZ     20000
`define TRD_ACQ_MS      100
`define TRD_TIMED_MS    1000

// ==========================================================
// Register byte offsets
`define TRD_OFF_CTRL    6'h00
`define TRD_OFF_SHOW    6'h04
`define TRD_OFF_TIMED   6'h08
`define TRD_OFF_WHOLE   6'h0C
`define TRD_OFF_DOUBLE  6'h10
`define TRD_OFF_ACQPER  6'h14
`define TRD_OFF_TIMPER  6'h18
`define TRD_OFF_STATUS  6'h1C
`define TRD_OFF_PEND    6'h20
`define TRD_OFF_COUNT   6'h24
`define TRD_OFF_REQAREA 6'h28

// ==========================================================
// Control fields and reset values
`define TRD_CTRL_EN     0
`define TRD_CTRL_PAGE   1
`define TRD_RST_MASK    16'h0000
`define TRD_ZERO32      32'h0000_0000
`define TRD_ONE32       32'h0000_0001

`endif

// ===== hdl/trend_xfer_pkg.sv
// Types for the trend request and transfer handshake block.
// Assumes trend_xfer_params.svh is compiled first.
`include "trend_xfer_params.svh"

package trend_xfer_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SCAN  = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_CLEAR = 4'b1000
  } state_t;

  // ==========================================================
  // Whole state of the top module
  typedef struct packed {
    state_t                  st;
    logic [31:0]             acqCnt;
    logic [31:0]             timCnt;
    logic [31:0]             acqPer;
    logic [31:0]             timPer;
    logic [`TRD_AREA_W-1:0]  showMask;
    logic [`TRD_AREA_W-1:0]  timedMask;
    logic [`TRD_AREA_W-1:0]  wholeMask;
    logic [`TRD_AREA_W-1:0]  doubleMask;
    logic [`TRD_AREA_W-1:0]  reqArea;
    logic [`TRD_AREA_W-1:0]  pendT;
    logic [`TRD_AREA_W-1:0]  pend1;
    logic [`TRD_AREA_W-1:0]  pend2;
    logic [`TRD_AREA_W-1:0]  clrMask;
    logic                    enable;
    logic                    page;
    logic                    acqDue;
    logic [1:0]              area;
    logic [`TRD_IDX_W-1:0]   trend;
    logic                    whole;
    logic                    fetchV;
    logic                    clrV;
    logic                    ack;
    logic [31:0]             rdata;
    logic [31:0]             fetchCount;
  } trd_state_t;

endpackage

// ===== hdl/lowest_bit_pick.sv
// Priority picker: index of the lowest set bit of a vector.
// Pure combinational; no clock or reset needed.
`timescale 1ns/100ps

module lowest_bit_pick #(
  parameter int W  = 16,
  parameter int IW = 4
) (
  // Candidate vector
  input  wire logic [W-1:0]  vec,
  // Result
  output logic               any,
  output logic [IW-1:0]      idx
);

  always_comb
  begin
    any = 1'b0;
    idx = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (vec[i])
      begin
        any = 1'b1;
        idx = IW'(i);
      end
    end
  end

endmodule // lowest_bit_pick

// ===== sim/trend_xfer_monitor.sv
// Port checker for the trend request and transfer handshake block.
// Assumes it is bound onto trend_transfer_handshake; one clock domain.
`timescale 1ns/100ps
`include "trend_xfer_params.svh"

module trend_xfer_monitor #(
  parameter int ACQ_CYCLES = 20,
  parameter int TIM_CYCLES = 50
) (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   srst,
  // Register bus
  input wire logic                   avsRead,
  input wire logic                   avsWrite,
  input wire logic                   avsWaitrequest,
  // Shared areas
  input wire logic [`TRD_AREA_W-1:0] reqAreaOut,
  input wire logic [`TRD_AREA_W-1:0] xfer1In,
  input wire logic [`TRD_AREA_W-1:0] xfer2In,
  // Fetch and clear
  input wire logic                   fetchValid,
  input wire logic                   fetchReady,
  input wire logic [`TRD_IDX_W-1:0]  fetchTrend,
  input wire logic                   fetchWhole,
  input wire logic                   fetchBuffer2,
  input wire logic                   fetchTimed,
  input wire logic                   clrValid,
  input wire logic                   clrReady,
  input wire logic                   clrArea2,
  input wire logic [`TRD_AREA_W-1:0] clrMask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Area word that the current fetch or clear refers to
  wire logic [`TRD_AREA_W-1:0] fsrc = fetchBuffer2 ? xfer2In : xfer1In;
  wire logic [`TRD_AREA_W-1:0] csrc = clrArea2 ? xfer2In : xfer1In;
  wire logic taken = (avsRead || avsWrite) && !avsWaitrequest;
  sequence fetch_done; fetchValid && fetchReady; endsequence
  sequence clr_done; clrValid && clrReady; endsequence
  sequence in_scan; !fetchValid && !clrValid; endsequence

  one_wait_a: assert property ($rose(avsRead || avsWrite) |->
    avsWaitrequest ##1 !avsWaitrequest) else $error("bus wait not one");
  req_top_a: assert property (!reqAreaOut[15])
    else $error("request area top bit set");
  req_cause_a: assert property ($changed(reqAreaOut) |->
    $past(taken) || $past(taken, 2)) else $error("request area moved");
  fetch_src_a: assert property (fetchValid && !fetchTimed |->
    fsrc[15] && fsrc[fetchTrend]) else $error("fetch without trigger");
  fetch_hold_a: assert property (fetchValid && !fetchReady |=>
    fetchValid && $stable({fetchTrend, fetchWhole, fetchBuffer2, fetchTimed}))
    else $error("fetch request moved");
  fetch_end_a: assert property (fetch_done |=> in_scan)
    else $error("fetch not released");
  clr_grp_a: assert property (clrValid |-> clrMask[15] &&
    csrc[15] && (clrMask & ~csrc) == '0) else $error("bad clear mask");
  clr_hold_a: assert property (clrValid && !clrReady |=>
    clrValid && $stable({clrMask, clrArea2})) else $error("clear moved");
  clr_end_a: assert property (clr_done |=> in_scan ##1 !fetchValid)
    else $error("clear not released");
  timed_a: assert property (fetchValid && fetchTimed |->
    !fetchBuffer2) else $error("timed fetch on area 2");
endmodule // trend_xfer_monitor

bind trend_transfer_handshake trend_xfer_monitor #(
  .ACQ_CYCLES(ACQ_CYCLES), .TIM_CYCLES(TIM_CYCLES)) mon (
  .clk(clk), .srst(srst), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsWaitrequest(avsWaitrequest), .reqAreaOut(reqAreaOut),
  .xfer1In(xfer1In), .xfer2In(xfer2In), .fetchValid(fetchValid),
  .fetchReady(fetchReady), .fetchTrend(fetchTrend),
  .fetchWhole(fetchWhole), .fetchBuffer2(fetchBuffer2),
  .fetchTimed(fetchTimed), .clrValid(clrValid), .clrReady(clrReady),
  .clrArea2(clrArea2), .clrMask(clrMask));

// ===== sim/plc_area_model.sv
// Controller model holding both transfer area words.
// Assumes the panel clears group bits through the clear handshake.
`timescale 1ns/100ps
`include "trend_xfer_params.svh"

module plc_area_model (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   srst,
  // Requests from the panel
  input wire logic                   fetchValid,
  input wire logic                   clrValid,
  input wire logic                   clrArea2,
  input wire logic [`TRD_AREA_W-1:0] clrMask,
  // Answers and area words
  output logic                       fetchReady,
  output logic                       clrReady,
  output logic [`TRD_AREA_W-1:0]     xfer1,
  output logic [`TRD_AREA_W-1:0]     xfer2
);
  int          dly = 0;
  int          fw;
  int          cw;
  logic        go = 1'b0;
  logic [15:0] n1 = 16'h0000;
  logic [15:0] n2 = 16'h0000;
  // Integer words; triggers ignore the request area entirely
  // The task only posts the words; the clocked process owns the areas
  task automatic trig(input logic [15:0] w1, input logic [15:0] w2);
    @(posedge clk);
    n1 <= w1;
    n2 <= w2;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  always @(posedge clk)
  begin
    if (srst)
    begin
      fetchReady <= 1'b0;
      clrReady <= 1'b0;
      fw <= 0;
      cw <= 0;
      xfer1 <= 16'h0000;
      xfer2 <= 16'h0000;
    end
    else
    begin
      fetchReady <= fetchValid && !fetchReady && fw >= dly;
      fw <= (fetchValid && !fetchReady) ? fw + 1 : 0;
      clrReady <= clrValid && !clrReady && cw >= dly;
      cw <= (clrValid && !clrReady) ? cw + 1 : 0;
      if (go && !xfer1[15] && !xfer2[15])
      begin
        xfer1 <= n1;
        xfer2 <= n2;
      end
      if (clrValid && clrReady && clrArea2)
        xfer2 <= xfer2 & ~clrMask;
      if (clrValid && clrReady && !clrArea2)
        xfer1 <= xfer1 & ~clrMask;
    end
  end
endmodule // plc_area_model

// ===== sim/trend_transfer_handshake_tb.sv
// Self-checking bench for the trend handshake block.
// Assumes the controller model and the bound checker are compiled.
`timescale 1ns/100ps
`include "trend_xfer_params.svh"

module trend_transfer_handshake_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  avsAddress = 6'h00;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0000_0000;
  logic [31:0] avsReaddata, rd;
  logic [15:0] reqAreaOut, xfer1In, xfer2In, clrMask;
  logic [3:0]  fetchTrend;
  logic        avsWaitrequest, fetchValid, fetchReady, fetchWhole;
  logic        fetchBuffer2, fetchTimed, clrValid, clrReady, clrArea2;
  int          fails = 0;
  int          total_checks = 0;
  int          n;
  logic [6:0]  fq[$];
  logic [16:0] cq[$];
  // Register rows: address, write data, read back
  logic [5:0]  rowA[8] = '{`TRD_OFF_SHOW, `TRD_OFF_WHOLE, `TRD_OFF_DOUBLE,
    `TRD_OFF_TIMED, `TRD_OFF_ACQPER, `TRD_OFF_TIMPER, `TRD_OFF_PEND, 6'h3C};
  logic [31:0] rowW[8] = '{32'h0001_4009, 32'h0000_0008, 32'h0000_0004,
    32'h0000_0000, 32'h0000_0014, 32'h0000_0032, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  logic [31:0] rowR[8] = '{32'h0000_4009, 32'h0000_0008, 32'h0000_0004,
    32'h0000_0000, 32'h0000_0014, 32'h0000_0032, 32'h0000_0000, 32'h0000_0000};

  always #25 clk = ~clk;

  trend_transfer_handshake #(.ACQ_CYCLES(20), .TIM_CYCLES(50)) dut (
    .clk(clk), .srst(srst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .reqAreaOut(reqAreaOut), .xfer1In(xfer1In), .xfer2In(xfer2In),
    .fetchValid(fetchValid), .fetchReady(fetchReady),
    .fetchTrend(fetchTrend), .fetchWhole(fetchWhole),
    .fetchBuffer2(fetchBuffer2), .fetchTimed(fetchTimed),
    .clrValid(clrValid), .clrReady(clrReady), .clrArea2(clrArea2),
    .clrMask(clrMask));
  plc_area_model plc (
    .clk(clk), .srst(srst), .fetchValid(fetchValid), .clrValid(clrValid),
    .clrArea2(clrArea2), .clrMask(clrMask), .fetchReady(fetchReady),
    .clrReady(clrReady), .xfer1(xfer1In), .xfer2(xfer2In));

  // Log every completed fetch and clear
  always @(posedge clk)
  begin
    if (fetchValid && fetchReady)
      fq.push_back({fetchTimed, fetchBuffer2, fetchWhole, fetchTrend});
    if (clrValid && clrReady)
      cq.push_back({clrArea2, clrMask});
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic limit(input int k, input int lim);
    if (k >= lim)
    begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsRead <= !w;
    avsWrite <= w;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (avsWaitrequest === 1'b0)
        break;
    end
    limit(k, 20);
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic run(input logic [15:0] w1, input logic [15:0] w2, input int d);
    int k;
    plc.dly = d;
    plc.trig(w1, w2);
    @(posedge clk);
    for (k = 0; k < 600 && (xfer1In[15] || xfer2In[15] || fetchValid
         || clrValid); k++)
      @(posedge clk);
    limit(k, 600);
  endtask
  task automatic popf(input logic [6:0] e);
    chk("fetch", {25'h0, e}, fq.size() ? {25'h0, fq.pop_front()} : 'x);
  endtask
  task automatic popc(input logic [16:0] e);
    chk("clear", {15'h0, e}, cq.size() ? {15'h0, cq.pop_front()} : 'x);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, rowA[i], rowW[i]);
      bus(1'b0, rowA[i], 32'h0000_0000);
      chk("register", rowR[i], rd);
    end
    bus(1'b1, `TRD_OFF_CTRL, 32'h0000_0003);
    repeat (2) @(negedge clk);
    chk("reqAreaOut", 32'h0000_4009, {16'h0000, reqAreaOut});
    bus(1'b0, `TRD_OFF_REQAREA, 32'h0000_0000);
    chk("reqArea", 32'h0000_4009, rd);
    run(16'h8009, 16'h8005, 0);
    popf(7'h00);
    popf(7'h13);
    popf(7'h22);
    popc(17'h0_8009);
    popc(17'h1_8004);
    chk("xfer2In", 32'h0000_0001, {16'h0000, xfer2In});
    run(16'hC000, 16'h8000, 3);
    popf(7'h0E);
    popc(17'h0_C000);
    popc(17'h1_8000);
    bus(1'b1, `TRD_OFF_TIMED, 32'h0000_0008);
    for (n = 0; n < 200 && fq.size() == 0; n++)
      @(posedge clk);
    limit(n, 200);
    popf(7'h43);
    bus(1'b1, `TRD_OFF_TIMED, 32'h0000_0000);
    repeat (60) @(posedge clk);
    chk("clears", 32'h0000_0000, cq.size());
    chk("fetches", 32'h0000_0000, fq.size());
    bus(1'b0, `TRD_OFF_COUNT, 32'h0000_0000);
    chk("count", 32'h0000_0005, rd);
    bus(1'b1, `TRD_OFF_CTRL, 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk("reqAreaOut", 32'h0000_0000, {16'h0000, reqAreaOut});
    bus(1'b1, `TRD_OFF_CTRL, 32'h0000_0003);
    repeat (2) @(negedge clk);
    chk("reqAreaOut", 32'h0000_4009, {16'h0000, reqAreaOut});
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("reqAreaOut", 32'h0000_0000, {16'h0000, reqAreaOut});
    bus(1'b0, `TRD_OFF_SHOW, 32'h0000_0000);
    chk("show", 32'h0000_0000, rd);
    tally_and_finish();
  end
endmodule // trend_transfer_handshake_tb
